// *** inc/ssbp_pkg.sv ***
`default_nettype none

package ssbp_pkg;

    // ------------------------------------------------------------------
    // Array organisation
    // ------------------------------------------------------------------
    localparam int ADDR_W    = 18;
    localparam int LANE_CNT  = 4;
    localparam int LANE_W    = 9;
    localparam int DATA_W    = LANE_CNT * LANE_W;
    localparam int DEPTH     = 1 << ADDR_W;
    localparam int BURST_W   = 2;

    // ------------------------------------------------------------------
    // Mode defaults when the mode pins float
    // ------------------------------------------------------------------
    localparam logic DEFAULT_INTERLEAVED = 1'b1;
    localparam logic DEFAULT_PIPELINED   = 1'b1;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_RESET  = 18'h00000;
    localparam logic [DATA_W-1:0] DATA_RESET  = 36'h000000000;
    localparam logic [1:0]        SYNC_RESET  = 2'h0;

    // ------------------------------------------------------------------
    // Access state, Gray coded along idle, read, write
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SSBP_IDLE  = 2'h0,
        SSBP_READ  = 2'h1,
        SSBP_WRITE = 2'h3
    } ssbp_state_t;

    // Burst address for a running count
    function automatic logic [BURST_W-1:0] burst_addr(
        input logic [BURST_W-1:0] preset,
        input logic [BURST_W-1:0] count,
        input logic               interleaved
    );
        burst_addr = interleaved ? (preset ^ count) : (preset + count);
    endfunction : burst_addr

endpackage : ssbp_pkg

`default_nettype wire

// *** inc/ssbp_burst_if.sv ***
`default_nettype none

interface ssbp_burst_if;
    logic                          load;
    logic                          step;
    logic                          interleaved;
    logic [ssbp_pkg::BURST_W-1:0]  preset;
    logic [ssbp_pkg::BURST_W-1:0]  low_bits;
    logic [ssbp_pkg::BURST_W-1:0]  next_low_bits;

    modport ctrl (
        output load,
        output step,
        output interleaved,
        output preset,
        input  low_bits,
        input  next_low_bits
    );

    modport counter (
        input  load,
        input  step,
        input  interleaved,
        input  preset,
        output low_bits,
        output next_low_bits
    );
endinterface : ssbp_burst_if

`default_nettype wire

// *** logic/ssbp_burst_counter.sv ***
`default_nettype none

module ssbp_burst_counter (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // Counter control
    ssbp_burst_if.counter    bif
);

    logic [ssbp_pkg::BURST_W-1:0] preset;
    logic [ssbp_pkg::BURST_W-1:0] count;
    logic [ssbp_pkg::BURST_W-1:0] next_count;

    assign next_count = count + 2'h1;

    // ------------------------------------------------------------------
    // Preset and running count
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            preset <= ssbp_pkg::SYNC_RESET;
        end else if (bif.load) begin
            preset <= bif.preset;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            count <= ssbp_pkg::SYNC_RESET;
        end else if (bif.load) begin
            count <= ssbp_pkg::SYNC_RESET;
        end else if (bif.step) begin
            count <= next_count;
        end
    end

    // Four-location wrap, linear or interleaved
    assign bif.low_bits = ssbp_pkg::burst_addr(preset, count,
                                               bif.interleaved);
    assign bif.next_low_bits = ssbp_pkg::burst_addr(preset, next_count,
                                                    bif.interleaved);

endmodule : ssbp_burst_counter

`default_nettype wire

// *** logic/ssbp_port.sv ***

`default_nettype none

module ssbp_port (
    // Clock and reset
    input  wire logic                          clk_sys,
    input  wire logic                          rst_n,
    // Address and strobes
    input  wire logic [ssbp_pkg::ADDR_W-1:0]   address,
    input  wire logic                          processor_address_strobe,
    input  wire logic                          controller_address_strobe,
    input  wire logic                          burst_advance_n,
    // Chip selects
    input  wire logic                          chip_select_primary_n,
    input  wire logic                          chip_select_secondary,
    input  wire logic                          chip_select_third_n,
    // Write controls
    input  wire logic                          global_write_n,
    input  wire logic                          byte_write_enable_n,
    input  wire logic [ssbp_pkg::LANE_CNT-1:0] lane_enables_n,
    // Asynchronous controls
    input  wire logic                          output_enable_n,
    input  wire logic                          sleep_request,
    // Mode pins, each with a sense of whether it is driven
    input  wire logic                          burst_order_mode,
    input  wire logic                          burst_order_mode_driven,
    input  wire logic                          output_register_mode,
    input  wire logic                          output_register_mode_driven,
    // Data lanes
    input  wire logic [ssbp_pkg::DATA_W-1:0]   data_lane_bus_in,
    output logic      [ssbp_pkg::DATA_W-1:0]   data_lane_bus_out,
    output logic                               data_lane_bus_oe
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [ssbp_pkg::DATA_W-1:0] mem [ssbp_pkg::DEPTH];

    ssbp_pkg::ssbp_state_t       state;
    ssbp_pkg::ssbp_state_t       next_state;

    logic [2:0]                  order_sync;
    logic [2:0]                  pipe_sync;
    logic                        interleaved;
    logic                        pipelined;

    logic                        selected;
    logic                        load;
    logic                        deselect;
    logic                        proceed;
    logic                        step;
    logic                        is_write;
    logic                        do_write;
    logic                        do_read;

    logic [ssbp_pkg::ADDR_W-1:0] access_addr;
    logic [ssbp_pkg::ADDR_W-1:0] next_access_addr;
    logic [ssbp_pkg::LANE_CNT-1:0] lane_mask;

    logic                        read_stage1;
    logic                        read_stage2;
    logic                        read_stage3;
    logic [ssbp_pkg::DATA_W-1:0] flow_data;
    logic [ssbp_pkg::DATA_W-1:0] out_reg;
    logic                        drive;

    ssbp_burst_if                bif ();

    // ------------------------------------------------------------------
    // Mode pins: three-stage sampling, change counted on agreement
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            order_sync <= {3{ssbp_pkg::DEFAULT_INTERLEAVED}};
        end else begin
            order_sync <= {order_sync[1:0],
                           burst_order_mode_driven ? burst_order_mode
                           : ssbp_pkg::DEFAULT_INTERLEAVED};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pipe_sync <= {3{ssbp_pkg::DEFAULT_PIPELINED}};
        end else begin
            pipe_sync <= {pipe_sync[1:0],
                          output_register_mode_driven ? output_register_mode
                          : ssbp_pkg::DEFAULT_PIPELINED};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            interleaved <= ssbp_pkg::DEFAULT_INTERLEAVED;
        end else if (order_sync[1] == order_sync[2]) begin
            interleaved <= order_sync[2];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pipelined <= ssbp_pkg::DEFAULT_PIPELINED;
        end else if (pipe_sync[1] == pipe_sync[2]) begin
            pipelined <= pipe_sync[2];
        end
    end

    // ------------------------------------------------------------------
    // Command decode for the current edge
    // ------------------------------------------------------------------
    assign selected = !chip_select_primary_n && chip_select_secondary
                      && !chip_select_third_n;

    // Writes are steered by global write first, then by byte write
    always_comb begin
        if (!global_write_n) begin
            lane_mask = {ssbp_pkg::LANE_CNT{1'b1}};
        end else if (!byte_write_enable_n) begin
            lane_mask = ~lane_enables_n;
        end else begin
            lane_mask = {ssbp_pkg::LANE_CNT{1'b0}};
        end
    end

    assign is_write = !global_write_n || !byte_write_enable_n;

    // Sleep suspends every access; stored words stay untouched
    always_comb begin
        load     = 1'b0;
        deselect = 1'b0;
        proceed  = 1'b0;
        if (!sleep_request) begin
            if (!processor_address_strobe || !controller_address_strobe) begin
                load     = selected;
                deselect = !selected;
            end else begin
                proceed  = (state != ssbp_pkg::SSBP_IDLE);
            end
        end
    end

    assign step = proceed && !burst_advance_n;

    // Processor strobe always opens with a read
    assign do_write = (load && processor_address_strobe && is_write)
                      || (proceed && is_write);
    assign do_read  = (load || proceed) && !do_write;

    always_comb begin
        next_state = state;
        case (state)
            ssbp_pkg::SSBP_IDLE: begin
                if (load) begin
                    next_state = do_write ? ssbp_pkg::SSBP_WRITE
                                          : ssbp_pkg::SSBP_READ;
                end
            end
            ssbp_pkg::SSBP_READ,
            ssbp_pkg::SSBP_WRITE: begin
                if (deselect) begin
                    next_state = ssbp_pkg::SSBP_IDLE;
                end else if (do_write) begin
                    next_state = ssbp_pkg::SSBP_WRITE;
                end else if (do_read) begin
                    next_state = ssbp_pkg::SSBP_READ;
                end
            end
            default: begin
                next_state = ssbp_pkg::SSBP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state <= ssbp_pkg::SSBP_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------------
    // Burst counter and access address
    // ------------------------------------------------------------------
    assign bif.load        = load;
    assign bif.step        = step;
    assign bif.interleaved = interleaved;
    assign bif.preset      = address[1:0];

    ssbp_burst_counter u_counter (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .bif     (bif)
    );

    always_comb begin
        if (load) begin
            next_access_addr = address;
        end else if (step) begin
            next_access_addr = {access_addr[ssbp_pkg::ADDR_W-1:2],
                                bif.next_low_bits};
        end else begin
            next_access_addr = access_addr;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            access_addr <= ssbp_pkg::ADDR_RESET;
        end else begin
            access_addr <= next_access_addr;
        end
    end

    // ------------------------------------------------------------------
    // Array write, completed within the edge
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst_n && do_write) begin
            for (int l = 0; l < ssbp_pkg::LANE_CNT; l++) begin
                if (lane_mask[l]) begin
                    mem[next_access_addr][l*ssbp_pkg::LANE_W +:
                                          ssbp_pkg::LANE_W]
                        <= data_lane_bus_in[l*ssbp_pkg::LANE_W +:
                                            ssbp_pkg::LANE_W];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Read pipeline, deselects travel the same stages
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            read_stage1 <= 1'b0;
        end else if (!sleep_request) begin
            read_stage1 <= do_read;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            read_stage2 <= 1'b0;
        end else if (!sleep_request) begin
            read_stage2 <= read_stage1;
        end
    end

    // Extra stage holds pipelined drive through the deselect cycle
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            read_stage3 <= 1'b0;
        end else if (!sleep_request) begin
            read_stage3 <= read_stage2;
        end
    end

    assign flow_data = mem[access_addr];

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            out_reg <= ssbp_pkg::DATA_RESET;
        end else if (read_stage1 && !sleep_request) begin
            out_reg <= flow_data;
        end
    end

    // ------------------------------------------------------------------
    // Data lane drive
    // ------------------------------------------------------------------
    // Drive spans the read's own stage and one more, so release follows
    // the first edge after a deselect when flow-through, the second when pipelined
    assign drive = pipelined ? (read_stage2 || read_stage3)
                             : (read_stage1 || read_stage2);

    assign data_lane_bus_out = pipelined ? out_reg : flow_data;
    assign data_lane_bus_oe  = drive && !output_enable_n
                               && !sleep_request;

endmodule : ssbp_port

`default_nettype wire

// *** dv/ssbp_port_monitor.sv ***
`default_nettype none

module ssbp_port_monitor (
    // Clock and reset
    input wire logic                        clk_sys,
    input wire logic                        rst_n,
    // Strobes and selects
    input wire logic                        processor_address_strobe,
    input wire logic                        controller_address_strobe,
    input wire logic                        chip_select_primary_n,
    input wire logic                        chip_select_secondary,
    input wire logic                        chip_select_third_n,
    // Write controls
    input wire logic                        global_write_n,
    input wire logic                        byte_write_enable_n,
    // Asynchronous controls
    input wire logic                        output_enable_n,
    input wire logic                        sleep_request,
    // Data lanes
    input wire logic [ssbp_pkg::DATA_W-1:0] data_lane_bus_out,
    input wire logic                        data_lane_bus_oe
);
    logic       sel;
    logic       ld;
    logic       wr;
    logic       rd_edge;
    logic       desel;
    logic       open;
    logic [2:0] since_rd;

    assign sel = !chip_select_primary_n && chip_select_secondary
                 && !chip_select_third_n;
    assign ld = !processor_address_strobe || !controller_address_strobe;
    assign wr = !global_write_n || !byte_write_enable_n;
    assign desel = !sleep_request && ld && !sel;
    assign rd_edge = !sleep_request
        && ((ld && sel && (!processor_address_strobe || !wr))
            || (!ld && open && !wr));

    // Edges since the last read, frozen while asleep
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            open     <= 1'b0;
            since_rd <= 3'h7;
        end else if (!sleep_request) begin
            open     <= ld ? sel : open;
            since_rd <= rd_edge ? 3'h0
                        : since_rd + {2'h0, since_rd != 3'h7};
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    chk_sleep_quiet: assert property (
        sleep_request |-> !data_lane_bus_oe) else $error("drive asleep");
    chk_oe_gate: assert property (
        output_enable_n |-> !data_lane_bus_oe) else $error("drive, oe high");
    chk_desel_release: assert property (
        desel [*3] |=> !data_lane_bus_oe) else $error("no release");
    chk_drive_cause: assert property (
        data_lane_bus_oe |-> since_rd <= 3'h2) else $error("stray drive");
    chk_read_drive: assert property (
        rd_edge ##1 !sleep_request |=>
        (data_lane_bus_oe || output_enable_n || sleep_request))
        else $error("read not driven");
    chk_desel_hold: assert property (
        rd_edge ##1 desel |=>
        (data_lane_bus_oe || output_enable_n || sleep_request))
        else $error("early release");
    chk_sleep_retain: assert property (
        sleep_request && $past(sleep_request) |->
        $stable(data_lane_bus_out)) else $error("data moved asleep");
    chk_reset_quiet: assert property (
        $rose(rst_n) |-> !data_lane_bus_oe [*2])
        else $error("drive after reset");
endmodule : ssbp_port_monitor

bind ssbp_port ssbp_port_monitor u_ssbp_port_monitor (
    .clk_sys, .rst_n, .processor_address_strobe,
    .controller_address_strobe, .chip_select_primary_n,
    .chip_select_secondary, .chip_select_third_n, .global_write_n,
    .byte_write_enable_n, .output_enable_n,
    .sleep_request, .data_lane_bus_out, .data_lane_bus_oe
);

`default_nettype wire

// *** dv/ssbp_host_model.sv ***
`default_nettype none

module ssbp_host_model (
    // Clock
    input  wire logic                        clk_sys,
    // Host side
    input  wire logic [ssbp_pkg::DATA_W-1:0] host_data,
    input  wire logic                        host_drive,
    // Device side
    input  wire logic [ssbp_pkg::DATA_W-1:0] dev_data,
    input  wire logic                        dev_oe,
    // Resolved lanes
    output logic      [ssbp_pkg::DATA_W-1:0] lanes
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [ssbp_pkg::DATA_W-1:0] last = '0;

    // Released lanes show the inverse of the last level
    always_comb begin
        lanes = dev_oe ? dev_data : (host_drive ? host_data : ~last);
    end

    always_ff @(posedge clk_sys) begin
        last <= lanes;
    end
endmodule : ssbp_host_model

`default_nettype wire

// *** dv/tb_ssbp_port.sv ***
`default_nettype none

module tb_ssbp_port;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int W = ssbp_pkg::DATA_W;
    localparam int AW = ssbp_pkg::ADDR_W;
    localparam logic [2:0] BAD [3] = '{3'b110, 3'b000, 3'b011};
    localparam logic [3:0] MODES [6] = '{4'hb, 4'hf, 4'ha, 4'he, 4'h0, 4'h5};

    logic          clk_sys = 1'b0;
    logic          rst_n = 1'b0;
    logic [AW-1:0] adr = '0;
    logic [AW-1:0] a0;
    logic [AW-1:0] base = '0;
    logic [1:0]    cnt = '0;
    logic          pas = 1'b1, cas = 1'b1, adv_n = 1'b1, opn = 1'b0;
    logic          cs1_n = 1'b0, cs2 = 1'b1, cs3_n = 1'b0;
    logic          gw_n = 1'b1, bw_n = 1'b1, oe_n = 1'b1, slp = 1'b0;
    logic          bom = 1'b0, bom_d = 1'b1, orm = 1'b1, orm_d = 1'b1;
    logic [3:0]    ln_n = 4'hf;
    logic [W-1:0]  hd = '0, dout, wdat;
    logic          hdrv = 1'b0, oe;
    logic [W-1:0]  mem [int];
    logic          h_rd [3] = '{1'b0, 1'b0, 1'b0};
    logic [W-1:0]  h_d [3];
    int            failures = 0, num_checks = 0, cycles = 0, dv = 0;
    int            seed = 32'h4a68a6f2;

    ssbp_port u_ssbp_port (
        .clk_sys(clk_sys), .rst_n(rst_n), .address(adr),
        .processor_address_strobe(pas), .controller_address_strobe(cas),
        .burst_advance_n(adv_n), .chip_select_primary_n(cs1_n),
        .chip_select_secondary(cs2), .chip_select_third_n(cs3_n),
        .global_write_n(gw_n), .byte_write_enable_n(bw_n),
        .lane_enables_n(ln_n), .output_enable_n(oe_n),
        .sleep_request(slp), .burst_order_mode(bom),
        .burst_order_mode_driven(bom_d), .output_register_mode(orm),
        .output_register_mode_driven(orm_d), .data_lane_bus_in(wdat),
        .data_lane_bus_out(dout), .data_lane_bus_oe(oe)
    );

    ssbp_host_model u_ssbp_host_model (
        .clk_sys(clk_sys), .host_data(hd), .host_drive(hdrv),
        .dev_data(dout), .dev_oe(oe), .lanes(wdat)
    );

    always #2.5 clk_sys = ~clk_sys;

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            conclude();
        end
    end

    task automatic conclude();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : conclude

    task automatic cmp(string n, logic [W-1:0] e, logic [W-1:0] s);
        num_checks++;
        if (e !== s) begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask : cmp

    // ------------------------------------------------------------------
    // Reference model, run at each edge on the sampled inputs
    // ------------------------------------------------------------------
    task automatic model();
        logic sel, wr, rd, ilv;
        logic [AW-1:0] a;
        sel = !cs1_n && cs2 && !cs3_n;
        wr = !gw_n || !bw_n;
        ilv = bom_d ? bom : 1'b1;
        if (slp) return;
        if (!pas || !cas) begin
            opn = sel;
            base = adr;
            cnt = '0;
            if (!pas) wr = 1'b0;
        end else if (!adv_n) cnt = cnt + 2'h1;
        a = {base[AW-1:2], ilv ? base[1:0] ^ cnt : base[1:0] + cnt};
        if (opn && wr) begin
            for (int l = 0; l < 4; l++) begin
                if (!gw_n || !ln_n[l]) mem[a][9*l +: 9] = wdat[9*l +: 9];
            end
        end
        rd = opn && !wr;
        h_rd[2] = h_rd[1];
        h_rd[1] = h_rd[0];
        h_rd[0] = rd;
        h_d[2] = h_d[1];
        h_d[1] = h_d[0];
        h_d[0] = rd ? mem[a] : '0;
    endtask : model

    task automatic step();
        int k;
        logic eo;
        @(posedge clk_sys);
        model();
        #1;
        k = (orm_d ? orm : 1'b1) ? 1 : 0;
        eo = !oe_n && !slp && (h_rd[k] || h_rd[k+1]);
        cmp("oe", W'(eo), W'(oe));
        if (eo && h_rd[k]) cmp("data", h_d[k], wdat);
    endtask : step

    // ------------------------------------------------------------------
    // Bus cycles
    // ------------------------------------------------------------------
    task automatic desel(input int n);
        {cs1_n, cs2, cs3_n} = BAD[dv % 3];
        {pas, cas} = dv[0] ? 2'b01 : 2'b10;
        dv++;
        repeat (n) step();
        {pas, cas, cs1_n, cs2, cs3_n} = 5'b11010;
    endtask : desel

    task automatic burst(input logic [AW-1:0] a, input logic w,
                         input logic p);
        adr = a;
        {pas, cas} = p ? 2'b01 : 2'b10;
        {gw_n, bw_n, oe_n, hdrv} = {!w, !w, w, w};
        ln_n = 4'($random(seed));
        hd = W'({$random(seed), $random(seed)});
        step();
        {pas, cas} = 2'b11;
        repeat (3) begin
            adv_n = w ? 1'b0 : 1'($random(seed));
            adr = AW'($random(seed));
            hd = W'({$random(seed), $random(seed)});
            step();
        end
        {adv_n, gw_n, bw_n, hdrv, ln_n} = 8'hef;
        desel(3);
    endtask : burst

    task automatic singles(input logic [AW-1:0] a);
        for (int i = 0; i < 4; i++) begin
            adr = {a[AW-1:2], 2'(i)};
            pas = 1'b0;
            oe_n = 1'($random(seed));
            step();
        end
        pas = 1'b1;
    endtask : singles

    initial begin
        repeat (2) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        a0 = AW'($random(seed));
        desel(6);
        burst(a0, 1'b1, 1'b0);
        for (int m = 0; m < 6; m++) begin
            {bom_d, bom, orm_d, orm} = MODES[m];
            desel(6);
            burst({a0[AW-1:2], 2'(m)}, 1'b0, m[0]);
        end
        {adr, cas, bw_n, oe_n, hdrv} = {a0, 4'h3};
        ln_n = 4'($random(seed));
        hd = W'({$random(seed), $random(seed)});
        step();
        {cas, bw_n, ln_n, hdrv} = 7'h7e;
        desel(3);
        singles(a0);
        slp = 1'b1;
        #1 cmp("sleep oe", '0, W'(oe));
        @(posedge clk_sys);
        #1;
        burst(a0, 1'b1, 1'b0);
        slp = 1'b0;
        desel(3);
        singles(a0);
        desel(3);
        conclude();
    end
endmodule : tb_ssbp_port

`default_nettype wire
